// ### design/ssrl_pkg.sv
// constants, command codes and shared decode for the status request logic
package ssrl_pkg;

    localparam int unsigned SSRL_W         = 8;
    localparam int unsigned SSRL_Q_DEPTH   = 256;

    // standard event register bit positions
    localparam int unsigned ESR_POWER_ON   = 7;
    localparam int unsigned ESR_USER_REQ   = 6;
    localparam int unsigned ESR_CMD_ERR    = 5;
    localparam int unsigned ESR_EXEC_ERR   = 4;
    localparam int unsigned ESR_DEV_ERR    = 3;
    localparam int unsigned ESR_QUERY_ERR  = 2;
    localparam int unsigned ESR_CTRL_REQ   = 1;
    localparam int unsigned ESR_OP_DONE    = 0;

    // status byte bit positions
    localparam int unsigned STB_EXT_LO     = 2;
    localparam int unsigned STB_MSG_AVAIL  = 4;
    localparam int unsigned STB_EVT_SUM    = 5;
    localparam int unsigned STB_REQ_SVC    = 6;

    // reset values and masks
    localparam logic [7:0] ESR_RESET       = 8'h80;
    localparam logic [7:0] ESE_RESET       = 8'h00;
    localparam logic [7:0] SRE_RESET       = 8'h00;
    localparam logic [7:0] SRE_KEEP_MASK   = 8'hBF;
    localparam logic [7:0] ESR_USED_MASK   = 8'hBD;
    localparam logic [7:0] ALL_BITS_MASK   = 8'hFF;

    // common commands and queries on the command port
    typedef enum logic [2:0] {
        CMD_SRE_WRITE = 3'h0,
        CMD_SRE_READ  = 3'h1,
        CMD_ESE_WRITE = 3'h2,
        CMD_ESE_READ  = 3'h3,
        CMD_ESR_READ  = 3'h4,
        CMD_STB_READ  = 3'h5,
        CMD_CLEAR     = 3'h6,
        CMD_OP_DONE   = 3'h7
    } ssrl_cmd_type;

    // operation-complete tracker states
    typedef enum logic [1:0] {
        OPC_IDLE = 2'b01,
        OPC_WAIT = 2'b10
    } ssrl_opc_type;

    // or of bits enabled by a mask, with a further keep mask
    function automatic logic ssrl_summary(input logic [7:0] bits,
                                          input logic [7:0] enable,
                                          input logic [7:0] keep);
        ssrl_summary = |(bits & enable & keep);
    endfunction : ssrl_summary

endpackage : ssrl_pkg

// ### design/ssrl_evt_if.sv
// carrier between the top and the standard event register
`timescale 1ns/1ps
`default_nettype none
interface ssrl_evt_if;
    logic [7:0] set_bits;
    logic       esr_clear;
    logic       ese_we;
    logic [7:0] ese_wdata;
    logic [7:0] standard_event_status;
    logic [7:0] event_enable_mask;
    logic       event_summary_bit;

    modport owner (input  set_bits, esr_clear, ese_we, ese_wdata,
                   output standard_event_status, event_enable_mask, event_summary_bit);
    modport user  (output set_bits, esr_clear, ese_we, ese_wdata,
                   input  standard_event_status, event_enable_mask, event_summary_bit);
endinterface : ssrl_evt_if
`default_nettype wire

// ### design/ssrl_event_reg.sv
// standard event register, its enable mask and the event summary
`timescale 1ns/1ps
`default_nettype none
module ssrl_event_reg (
    // clock and control
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // event carrier
    ssrl_evt_if.owner   ev
);
    import ssrl_pkg::*;

    logic [7:0] esr_r;
    logic [7:0] esr_nxt;
    logic [7:0] ese_r;
    logic [7:0] ese_nxt;

    always_comb begin
        esr_nxt = ev.esr_clear ? 8'h00 : esr_r;
        esr_nxt = (esr_nxt | ev.set_bits) & ESR_USED_MASK;
        ese_nxt = ev.ese_we ? ev.ese_wdata : ese_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            esr_r <= ESR_RESET;
            ese_r <= ESE_RESET;
        end else if (ce) begin
            esr_r <= esr_nxt;
            ese_r <= ese_nxt;
        end
    end

    assign ev.standard_event_status = esr_r;
    assign ev.event_enable_mask = ese_r;
    assign ev.event_summary_bit = ssrl_summary(esr_r, ese_r, ALL_BITS_MASK);

endmodule : ssrl_event_reg
`default_nettype wire

// ### design/ssrl_out_queue.sv
// response output queue with flush
`timescale 1ns/1ps
`default_nettype none
module ssrl_out_queue #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned W     = 8
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // fill, drain, flush
    input  wire logic         push,
    input  wire logic [W-1:0] push_data,
    input  wire logic         pop,
    input  wire logic         flush,
    // state
    output logic [W-1:0]      head_data,
    output logic              empty,
    output logic              full
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          do_push;
    logic          do_pop;

    assign empty     = (cnt_r == '0);
    assign full      = (cnt_r == (AW+1)'(DEPTH));
    assign head_data = mem[rd_ptr_r];
    assign do_push   = push && !full && !flush;
    assign do_pop    = pop && !empty && !flush;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt    = cnt_r;
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt    = '0;
        end else begin
            if (do_push) begin
                wr_ptr_nxt = wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
                rd_ptr_nxt = rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            cnt_nxt = cnt_r + {{AW{1'b0}}, do_push}
                            - {{AW{1'b0}}, do_pop};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else if (ce) begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r    <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

endmodule : ssrl_out_queue
`default_nettype wire

// ### design/ssrl_top.sv
// status byte, service request and query error logic
//
// Behaviour
// - each enabled status bit that becomes set raises a service request.
// - enabled message-available bit requests service each time it rises.
// - service mask query returns its binary weighted value, 0 to 63 or 128 to 191.
// - bit 6 of the service mask always reads zero.
// - service mask write sets bits 0-5 and 7 from the supplied integer.
// - the written value of service mask bit 6 is ignored.
// - event mask bits choose which event bits feed the event summary.
// - power-on event bit is set at power-up.
// - user request event bit is unused and always zero.
// - command errors set event bit 5.
// - legal but unexecutable messages set event bit 4.
// - other device errors set event bit 3.
// - reading an empty queue or losing queue data sets bit 2.
// - control request event bit is unused and always zero.
// - bit 0 is set only by operation-complete once operations finish.
// - incomplete message aborts, flushes output and reports query error.
// - listen address during a response flushes output, query error.
// - new message before response is read discards it, query error.
// - output queue holds 256 bytes; overflow is a query error.
// - master summary ors enabled status bits 0-5 and 7.
// - a serial poll clears the request-service bit at once.
// - clear command clears events, the event summary and the request flag, never enable masks.
// - reading the event register clears it afterwards.
`timescale 1ns/1ps
`default_nettype none
module ssrl_top #(
    parameter int unsigned Q_DEPTH = ssrl_pkg::SSRL_Q_DEPTH
) (
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // common commands and queries
    input  wire logic                 cmd_valid,
    input  wire ssrl_pkg::ssrl_cmd_type cmd_code,
    input  wire logic [7:0]           cmd_data,
    output logic                      rsp_valid,
    output logic [7:0]                rsp_data,
    // serial poll and service request
    input  wire logic                 poll_strobe,
    output logic                      poll_valid,
    output logic [7:0]                poll_data,
    output logic                      srq,
    // response bytes from the command engine
    input  wire logic                 resp_wr,
    input  wire logic [7:0]           resp_byte,
    // response bytes to the controller
    input  wire logic                 bus_rd,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    // message and error events
    input  wire logic                 cmd_error,
    input  wire logic                 exec_error,
    input  wire logic                 dev_error,
    input  wire logic                 msg_incomplete,
    input  wire logic                 listen_addr,
    input  wire logic                 new_program,
    input  wire logic                 ops_done,
    // extended register summaries for status bits 3 and 2
    input  wire logic [1:0]           ext_summary
);
    import ssrl_pkg::*;

    ssrl_evt_if evt ();

    logic [7:0]   sre_r;
    logic [7:0]   sre_nxt;
    logic [7:0]   stb;
    logic [7:0]   stb_prev_r;
    logic [7:0]   stb_prev_nxt;
    logic         master_summary;
    logic         new_cause;
    logic         rqs_r;
    logic         rqs_nxt;
    ssrl_opc_type opc_r;
    ssrl_opc_type opc_nxt;
    logic         op_done_set;
    logic         rsp_valid_r;
    logic         rsp_valid_nxt;
    logic [7:0]   rsp_data_r;
    logic [7:0]   rsp_data_nxt;
    logic         poll_valid_r;
    logic [7:0]   poll_data_r;
    logic         rd_valid_r;
    logic         rd_valid_nxt;
    logic [7:0]   rd_data_r;
    logic [7:0]   rd_data_nxt;
    logic         q_empty;
    logic         q_full;
    logic [7:0]   q_head;
    logic         q_flush;
    logic         q_err;
    logic         is_cmd_clear;

    ssrl_event_reg u_event (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .ev  (evt)
    );

    ssrl_out_queue #(
        .DEPTH (Q_DEPTH),
        .W     (SSRL_W)
    ) u_queue (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .push      (resp_wr),
        .push_data (resp_byte),
        .pop       (bus_rd),
        .flush     (q_flush),
        .head_data (q_head),
        .empty     (q_empty),
        .full      (q_full)
    );

    assign is_cmd_clear = cmd_valid && (cmd_code == CMD_CLEAR);

    // status byte assembly
    always_comb begin
        stb                = 8'h00;
        stb[STB_EVT_SUM]   = evt.event_summary_bit;
        stb[STB_MSG_AVAIL] = !q_empty;
        stb[STB_EXT_LO+:2] = ext_summary;
        master_summary = ssrl_summary(stb, sre_r, SRE_KEEP_MASK);
        new_cause = ssrl_summary(stb & ~stb_prev_r, sre_r, SRE_KEEP_MASK);
    end

    // query error and output flush
    always_comb begin
        q_flush = msg_incomplete;
        q_flush = q_flush | (listen_addr && !q_empty);
        q_flush = q_flush | (new_program && !q_empty);
        q_err   = q_flush | (bus_rd && q_empty);
        q_err   = q_err | (resp_wr && q_full && !q_flush);
    end

    // operation-complete tracker
    always_comb begin
        opc_nxt     = opc_r;
        op_done_set = 1'b0;
        unique case (opc_r)
            OPC_IDLE: begin
                if (cmd_valid && cmd_code == CMD_OP_DONE) begin
                    opc_nxt = OPC_WAIT;
                end
            end
            OPC_WAIT: begin
                if (ops_done) begin
                    op_done_set = 1'b1;
                    opc_nxt     = OPC_IDLE;
                end
            end
        endcase
    end

    // event register drive
    always_comb begin
        evt.set_bits               = 8'h00;
        evt.set_bits[ESR_CMD_ERR]  = cmd_error;
        evt.set_bits[ESR_EXEC_ERR] = exec_error;
        evt.set_bits[ESR_DEV_ERR]  = dev_error;
        evt.set_bits[ESR_QUERY_ERR] = q_err;
        evt.set_bits[ESR_OP_DONE]  = op_done_set;
        evt.esr_clear = is_cmd_clear
                      || (cmd_valid && cmd_code == CMD_ESR_READ);
        evt.ese_we    = cmd_valid && (cmd_code == CMD_ESE_WRITE);
        evt.ese_wdata = cmd_data;
    end

    // service mask, request flag, commands
    always_comb begin
        sre_nxt       = sre_r;
        stb_prev_nxt  = stb;
        rqs_nxt       = rqs_r;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt  = rsp_data_r;
        if (poll_strobe || is_cmd_clear) begin
            rqs_nxt = 1'b0;
        end
        if (new_cause) begin
            rqs_nxt = 1'b1;
        end
        if (cmd_valid) begin
            unique case (cmd_code)
                CMD_SRE_WRITE: begin
                    sre_nxt = cmd_data & SRE_KEEP_MASK;
                end
                CMD_SRE_READ: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = sre_r & SRE_KEEP_MASK;
                end
                CMD_ESE_READ: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = evt.event_enable_mask;
                end
                CMD_ESR_READ: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = evt.standard_event_status;
                end
                CMD_STB_READ: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = stb;
                    rsp_data_nxt[STB_REQ_SVC] = master_summary;
                end
                CMD_ESE_WRITE, CMD_CLEAR, CMD_OP_DONE: begin
                    rsp_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    // controller reads of response bytes
    always_comb begin
        rd_valid_nxt = bus_rd && !q_empty && !q_flush;
        rd_data_nxt  = rd_valid_nxt ? q_head : rd_data_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sre_r        <= SRE_RESET;
            stb_prev_r   <= 8'h00;
            rqs_r        <= 1'b0;
            opc_r        <= OPC_IDLE;
            rsp_valid_r  <= 1'b0;
            rsp_data_r   <= 8'h00;
            poll_valid_r <= 1'b0;
            poll_data_r  <= 8'h00;
            rd_valid_r   <= 1'b0;
            rd_data_r    <= 8'h00;
        end else if (ce) begin
            sre_r        <= sre_nxt;
            stb_prev_r   <= stb_prev_nxt;
            rqs_r        <= rqs_nxt;
            opc_r        <= opc_nxt;
            rsp_valid_r  <= rsp_valid_nxt;
            rsp_data_r   <= rsp_data_nxt;
            poll_valid_r <= poll_strobe;
            if (poll_strobe) begin
                poll_data_r <= {stb[7], rqs_r, stb[5:0]};
            end
            rd_valid_r   <= rd_valid_nxt;
            rd_data_r    <= rd_data_nxt;
        end
    end

    assign rsp_valid  = rsp_valid_r;
    assign rsp_data   = rsp_data_r;
    assign poll_valid = poll_valid_r;
    assign poll_data  = poll_data_r;
    assign srq        = rqs_r;
    assign rd_valid   = rd_valid_r;
    assign rd_data    = rd_data_r;

endmodule : ssrl_top
`default_nettype wire

// ### bench/ssrl_ctrl_model.sv
// controller model that serial-polls whenever service is requested
`timescale 1ns/1ps
`default_nettype none
module ssrl_ctrl_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // service request and poll answer
    input  wire logic       srq,
    input  wire logic       poll_valid,
    input  wire logic [7:0] poll_data,
    // poll request and last status seen
    output logic            poll_strobe,
    output logic [7:0]      last_poll
);
    // one poll per request, strobe dropped after its edge
    always_ff @(posedge clk) begin
        if (rst) begin
            poll_strobe <= 1'b0;
            last_poll   <= 8'h00;
        end else begin
            poll_strobe <= srq && !poll_strobe;
            if (poll_valid) begin
                last_poll <= poll_data;
            end
        end
    end
endmodule : ssrl_ctrl_model
`default_nettype wire

// ### bench/ssrl_top_chk.sv
// port-level assertions for the status request logic
`timescale 1ns/1ps
`default_nettype none
module ssrl_top_chk
    import ssrl_pkg::*;
#(
    parameter int unsigned Q_DEPTH = 256
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // command port
    input  wire logic         cmd_valid,
    input  wire ssrl_cmd_type cmd_code,
    input  wire logic [7:0]   cmd_data,
    input  wire logic         rsp_valid,
    input  wire logic [7:0]   rsp_data,
    // poll and request
    input  wire logic         poll_strobe,
    input  wire logic         poll_valid,
    input  wire logic [7:0]   poll_data,
    input  wire logic         srq,
    // queue read
    input  wire logic         bus_rd,
    input  wire logic         rd_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_sre_wr; ce && cmd_valid && cmd_code == CMD_SRE_WRITE; endsequence
    sequence s_sre_rd; ce && cmd_valid && cmd_code == CMD_SRE_READ; endsequence
    sequence s_ese_wr; ce && cmd_valid && cmd_code == CMD_ESE_WRITE; endsequence
    sequence s_ese_rd; ce && cmd_valid && cmd_code == CMD_ESE_READ; endsequence
    sequence s_esr_rd; ce && cmd_valid && cmd_code == CMD_ESR_READ; endsequence

    property p_sre_wr_rd;
        s_sre_wr ##1 (ce && !cmd_valid) ##1 s_sre_rd
            |=> rsp_data == ($past(cmd_data, 3) & 8'hBF);
    endproperty
    a_sre_wr_rd: assert property (p_sre_wr_rd)
        else $error("service mask read back wrong");
    property p_sre_b6;
        s_sre_rd |=> rsp_valid && !rsp_data[6];
    endproperty
    a_sre_b6: assert property (p_sre_b6)
        else $error("service mask bit 6 not zero");
    property p_esr_b6;
        s_esr_rd |=> rsp_valid && !rsp_data[6];
    endproperty
    a_esr_b6: assert property (p_esr_b6)
        else $error("user request event bit set");
    property p_esr_b1;
        s_esr_rd |=> !rsp_data[1];
    endproperty
    a_esr_b1: assert property (p_esr_b1)
        else $error("control request event bit set");
    property p_wr_silent;
        ce && cmd_valid && (cmd_code == CMD_SRE_WRITE
            || cmd_code == CMD_ESE_WRITE || cmd_code == CMD_CLEAR) |=> !rsp_valid;
    endproperty
    a_wr_silent: assert property (p_wr_silent)
        else $error("write gave an answer");
    property p_ese_wr_rd;
        s_ese_wr ##1 (ce && !cmd_valid) ##1 s_ese_rd
            |=> rsp_valid && rsp_data == $past(cmd_data, 3);
    endproperty
    a_ese_wr_rd: assert property (p_ese_wr_rd)
        else $error("event mask read back wrong");
    property p_poll;
        ce && poll_strobe && srq |=> poll_valid && poll_data[6];
    endproperty
    a_poll: assert property (p_poll)
        else $error("poll lost the request flag");
    property p_srq_fall;
        $fell(srq) |-> $past(poll_strobe) || $past(rst)
            || $past(cmd_valid && cmd_code == CMD_CLEAR);
    endproperty
    a_srq_fall: assert property (p_srq_fall)
        else $error("request dropped without poll or clear");
    property p_clr;
        ce && cmd_valid && cmd_code == CMD_CLEAR |=> !srq;
    endproperty
    a_clr: assert property (p_clr)
        else $error("request kept after clear");
    property p_rd_cause;
        rd_valid |-> $past(bus_rd && ce);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("queue byte without a read");
endmodule : ssrl_top_chk
`default_nettype wire

// ### bench/ssrl_top_tb.sv
// self-checking bench for the status request logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ssrl_top_tb;
    import ssrl_pkg::*;
    localparam int unsigned QD = 8;
    logic         clk, rst, ce, cmd_valid, poll_strobe, poll_valid, srq;
    logic         resp_wr, bus_rd, rd_valid, ops_done, rsp_valid;
    ssrl_cmd_type cmd_code;
    logic [7:0]   cmd_data, rsp_data, poll_data, resp_byte, rd_data, last_poll;
    logic [5:0]   evv;
    logic [1:0]   ext;
    logic [7:0]   vals [4] = '{8'hFF, 8'h40, 8'hA5, 8'h00};
    int           n_fail, checks_done, cyc;

    ssrl_top #(.Q_DEPTH(QD)) dut (.clk(clk), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .poll_strobe(poll_strobe),
        .poll_valid(poll_valid), .poll_data(poll_data), .srq(srq),
        .resp_wr(resp_wr), .resp_byte(resp_byte), .bus_rd(bus_rd),
        .rd_valid(rd_valid), .rd_data(rd_data), .cmd_error(evv[0]),
        .exec_error(evv[1]), .dev_error(evv[2]), .msg_incomplete(evv[3]),
        .listen_addr(evv[4]), .new_program(evv[5]), .ops_done(ops_done),
        .ext_summary(ext));
    ssrl_ctrl_model u_ctrl (.clk(clk), .rst(rst), .srq(srq),
        .poll_valid(poll_valid), .poll_data(poll_data),
        .poll_strobe(poll_strobe), .last_poll(last_poll));

    always #2 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic cmd(input ssrl_cmd_type c, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_data  <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : cmd

    task automatic query(input ssrl_cmd_type c, input logic [7:0] e);
        cmd(c, 8'h00);
        #1;
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data, e)
    endtask : query

    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        evv <= m;
        @(posedge clk);
        evv <= 6'h00;
    endtask : pulse

    task automatic push(input logic [7:0] b);
        @(posedge clk);
        resp_wr   <= 1'b1;
        resp_byte <= b;
        @(posedge clk);
        resp_wr   <= 1'b0;
    endtask : push

    task automatic pop(input logic v, input logic [7:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        `CHK(rd_valid, v)
        if (v) `CHK(rd_data, e)
    endtask : pop

    initial begin
        clk = 0; rst = 1; ce = 1; cmd_valid = 0; cmd_code = CMD_SRE_READ;
        cmd_data = 0; resp_wr = 0; resp_byte = 0; bus_rd = 0; evv = 0;
        ops_done = 0; ext = 0; n_fail = 0; checks_done = 0; cyc = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        query(CMD_ESR_READ, 8'h80);
        query(CMD_ESR_READ, 8'h00);
        query(CMD_SRE_READ, 8'h00);
        $display("test reset done");
        foreach (vals[i]) begin
            cmd(CMD_SRE_WRITE, vals[i]);
            query(CMD_SRE_READ, vals[i] & 8'hBF);
        end
        cmd(CMD_ESE_WRITE, 8'hFF);
        query(CMD_ESE_READ, 8'hFF);
        cmd(CMD_ESE_WRITE, 8'h00);
        $display("test masks done");
        for (int i = 0; i < 3; i++) begin
            pulse(6'h01 << i);
            query(CMD_STB_READ, 8'h00);
            query(CMD_ESR_READ, 8'h20 >> i);
        end
        $display("test events done");
        pop(1'b0, 8'h00);
        query(CMD_ESR_READ, 8'h04);
        for (int i = 0; i <= QD; i++) push(8'(i));
        query(CMD_ESR_READ, 8'h04);
        for (int i = 0; i < QD; i++) pop(1'b1, 8'(i));
        for (int i = 3; i < 6; i++) begin
            push(8'h5A);
            query(CMD_STB_READ, 8'h10);
            pulse(6'h01 << i);
            query(CMD_STB_READ, 8'h00);
            query(CMD_ESR_READ, 8'h04);
        end
        $display("test queue done");
        @(posedge clk);
        ops_done <= 1'b1;
        @(posedge clk);
        ops_done <= 1'b0;
        cmd(CMD_OP_DONE, 8'h00);
        query(CMD_ESR_READ, 8'h00);
        @(posedge clk);
        ops_done <= 1'b1;
        @(posedge clk);
        ops_done <= 1'b0;
        query(CMD_ESR_READ, 8'h01);
        $display("test complete done");
        cmd(CMD_ESE_WRITE, 8'h20);
        cmd(CMD_SRE_WRITE, 8'h20);
        pulse(6'h01);
        repeat (6) @(posedge clk);
        #1;
        `CHK(last_poll, 8'h60)
        `CHK(srq, 1'b0)
        @(posedge clk);
        ext <= 2'b10;
        query(CMD_STB_READ, 8'h68);
        query(CMD_ESR_READ, 8'h20);
        pulse(6'h01);
        cmd(CMD_CLEAR, 8'h00);
        #1;
        `CHK(srq, 1'b0)
        query(CMD_ESR_READ, 8'h00);
        query(CMD_SRE_READ, 8'h20);
        query(CMD_STB_READ, 8'h08);
        @(posedge clk);
        ext <= 2'b00;
        cmd(CMD_SRE_WRITE, 8'h10);
        push(8'hAA);
        repeat (6) @(posedge clk);
        #1;
        `CHK(last_poll, 8'h50)
        pop(1'b1, 8'hAA);
        @(posedge clk);
        ce <= 1'b0;
        cmd(CMD_SRE_WRITE, 8'h01);
        ce <= 1'b1;
        query(CMD_SRE_READ, 8'h10);
        $display("test service done");
        finish_test();
    end
endmodule : ssrl_top_tb

bind ssrl_top ssrl_top_chk #(.Q_DEPTH(Q_DEPTH)) u_chk (.clk(clk), .rst(rst),
    .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .poll_strobe(poll_strobe),
    .poll_valid(poll_valid), .poll_data(poll_data), .srq(srq),
    .bus_rd(bus_rd), .rd_valid(rd_valid));
`default_nettype wire
